/* File: design/sfid_top.sv */
// Serial flash identity reads and security register erase, device side
`include "sfid_consts.svh"
`default_nettype none
`timescale 1ns/1ps
module sfid_top
   import sfid_pkg::*;
#(
   parameter logic [7:0] MFR_ID = 8'h5c,     // Arbitrary value
   parameter logic [7:0] DEV_ID = 8'h16,     // Arbitrary value
   parameter logic [7:0] MEM_TYPE = 8'h60,   // Arbitrary value
   parameter logic [7:0] CAPACITY = 8'h17,   // Arbitrary value
   parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89ab_cdef, // Arbitrary
   parameter int ERASE_CYCLES = `SFID_SEC_ERASE_TIME_US * `SFID_CLK_MHZ,
   parameter int FIFO_DEPTH = `SFID_FIFO_DEPTH
)
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic spi_cs_n,
   input wire logic spi_sclk,
   input wire logic [3:0] spi_io_in,
   output logic [3:0] spi_io_out,
   output logic [3:0] spi_io_oe,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata
);
   sfid_pins_t pins_s1_r;
   sfid_pins_t pins_s2_r;
   logic sclk_d_r;
   logic cs_d_r;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_rise;
   sfid_phase_t phase_r;
   sfid_phase_t phase_d_r;
   logic [5:0] clk_left_r;
   logic [7:0] cmd_r;
   logic [7:0] cmd_sh;
   logic [23:0] addr_r;
   logic [23:0] addr_nxt;
   sfid_lanes_t in_lanes_r;
   sfid_lanes_t out_lanes_r;
   sfid_src_t src_r;
   logic out_start;
   logic [7:0] start_idx;
   logic prod_en_r;
   logic [7:0] idx_r;
   logic [7:0] src_byte;
   logic fifo_ready;
   logic fifo_valid;
   logic [7:0] fifo_data;
   logic pop;
   logic [7:0] out_byte_r;
   logic [2:0] out_left_r;
   logic [7:0] cur_byte;
   logic write_latch_r;
   logic pd_r;
   logic busy_r;
   logic [31:0] erase_cnt_r;
   logic erase_done;
   logic erase_go;
   logic [3:0] erase_sel;
   logic [1:0] last_sel_r;
   logic [7:0] erase_total_r;
   logic [2:0] otp_lock_bits_r;
   logic [7:0] tbl_idx_r;
   logic [7:0] table_r [256];
   logic [7:0] status_byte;
   logic frame_end_hold;

   // Two-stage synchronisers for every link pin
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         pins_s1_r <= '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};
         pins_s2_r <= '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};
         sclk_d_r <= 1'b0;
         cs_d_r <= 1'b1;
      end
      else
      begin
         pins_s1_r <= '{cs_n: spi_cs_n, sclk: spi_sclk, io: spi_io_in};
         pins_s2_r <= pins_s1_r;
         sclk_d_r <= pins_s2_r.sclk;
         cs_d_r <= pins_s2_r.cs_n;
      end
   end

   // Link clock edges inside a frame, and the end of a frame
   assign sclk_rise = pins_s2_r.sclk & ~sclk_d_r & ~pins_s2_r.cs_n;
   assign sclk_fall = ~pins_s2_r.sclk & sclk_d_r & ~pins_s2_r.cs_n;
   assign cs_rise = pins_s2_r.cs_n & ~cs_d_r;
   assign cmd_sh = {cmd_r[6:0], pins_s2_r.io[0]};

   // Address shift, one, two or four bits per clock
   always_comb
   begin
      unique case (in_lanes_r)
         SFID_LANE_1: addr_nxt = {addr_r[22:0], pins_s2_r.io[0]};
         SFID_LANE_2: addr_nxt = {addr_r[21:0], pins_s2_r.io[1:0]};
         SFID_LANE_4: addr_nxt = {addr_r[19:0], pins_s2_r.io[3:0]};
         default: addr_nxt = addr_r;
      endcase
   end

   // Frame sequencer: instruction, address, mode, dummy and output phases
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         phase_r <= SFID_PH_CMD;
         clk_left_r <= `SFID_CMD_CLKS - 6'h01;
         cmd_r <= 8'h00;
         addr_r <= 24'h000000;
         in_lanes_r <= SFID_LANE_1;
         out_lanes_r <= SFID_LANE_1;
         src_r <= SFID_SRC_MFR_DEV;
      end
      else if (pins_s2_r.cs_n)
      begin
         phase_r <= SFID_PH_CMD;
         clk_left_r <= `SFID_CMD_CLKS - 6'h01;
      end
      else if (sclk_rise)
      begin
         if (clk_left_r != 6'h00)
            clk_left_r <= clk_left_r - 6'h01;
         unique case (phase_r)
            SFID_PH_CMD:
            begin
               cmd_r <= cmd_sh;
               if (clk_left_r == 6'h00)
               begin
                  in_lanes_r <= SFID_LANE_1;
                  out_lanes_r <= SFID_LANE_1;
                  clk_left_r <= `SFID_ADDR_CLKS_1 - 6'h01;
                  if (pd_r)
                  begin
                     phase_r <= (cmd_sh == `SFID_OP_RELEASE) ?
                                SFID_PH_HOLD : SFID_PH_IGNORE;
                  end
                  else if (busy_r)
                  begin
                     phase_r <= (cmd_sh == `SFID_OP_RDSR) ?
                                SFID_PH_OUT : SFID_PH_IGNORE;
                     src_r <= SFID_SRC_STATUS;
                  end
                  else
                  begin
                     case (cmd_sh)
                        `SFID_OP_ID_SINGLE:
                        begin
                           phase_r <= SFID_PH_ADDR;
                           src_r <= SFID_SRC_MFR_DEV;
                        end
                        `SFID_OP_ID_DUAL:
                        begin
                           phase_r <= SFID_PH_ADDR;
                           src_r <= SFID_SRC_MFR_DEV;
                           in_lanes_r <= SFID_LANE_2;
                           out_lanes_r <= SFID_LANE_2;
                           clk_left_r <= `SFID_ADDR_CLKS_2 - 6'h01;
                        end
                        `SFID_OP_ID_QUAD:
                        begin
                           phase_r <= SFID_PH_DUMMY;
                           src_r <= SFID_SRC_MFR_DEV;
                           in_lanes_r <= SFID_LANE_4;
                           out_lanes_r <= SFID_LANE_4;
                           clk_left_r <= `SFID_QUAD_DUMMY_CLKS - 6'h01;
                        end
                        `SFID_OP_UID:
                        begin
                           phase_r <= SFID_PH_DUMMY;
                           src_r <= SFID_SRC_UID;
                           clk_left_r <= `SFID_UID_DUMMY_CLKS - 6'h01;
                        end
                        `SFID_OP_STD_ID:
                        begin
                           phase_r <= SFID_PH_OUT;
                           src_r <= SFID_SRC_STD_ID;
                        end
                        `SFID_OP_TABLE:
                        begin
                           phase_r <= SFID_PH_ADDR;
                           src_r <= SFID_SRC_TABLE;
                        end
                        `SFID_OP_SEC_ERASE:
                           phase_r <= SFID_PH_ADDR;
                        `SFID_OP_RDSR:
                        begin
                           phase_r <= SFID_PH_OUT;
                           src_r <= SFID_SRC_STATUS;
                        end
                        `SFID_OP_WREN, `SFID_OP_WRDI, `SFID_OP_PDOWN,
                        `SFID_OP_RELEASE:
                           phase_r <= SFID_PH_HOLD;
                        default:
                           phase_r <= SFID_PH_IGNORE;
                     endcase
                  end
               end
            end
            SFID_PH_ADDR:
            begin
               addr_r <= addr_nxt;
               if (clk_left_r == 6'h00)
               begin
                  case (cmd_r)
                     // bypass bits are taken and not used
                     `SFID_OP_ID_DUAL:
                     begin
                        phase_r <= SFID_PH_MODE;
                        clk_left_r <= `SFID_MODE_CLKS - 6'h01;
                     end
                     // eight dummies, data from 41st clock
                     `SFID_OP_TABLE:
                     begin
                        phase_r <= SFID_PH_DUMMY;
                        clk_left_r <= `SFID_TABLE_DUMMY_CLKS - 6'h01;
                     end
                     `SFID_OP_SEC_ERASE:
                        phase_r <= SFID_PH_HOLD;
                     default:
                        phase_r <= SFID_PH_OUT;
                  endcase
               end
            end
            SFID_PH_MODE:
            begin
               if (clk_left_r == 6'h00)
                  phase_r <= SFID_PH_OUT;
            end
            SFID_PH_DUMMY:
            begin
               if (clk_left_r == 6'h00)
               begin
                  if (cmd_r == `SFID_OP_ID_QUAD)
                  begin
                     phase_r <= SFID_PH_ADDR;
                     clk_left_r <= `SFID_ADDR_CLKS_4 - 6'h01;
                  end
                  else
                     phase_r <= SFID_PH_OUT;
               end
            end
            // any extra clock voids the instruction
            SFID_PH_HOLD: phase_r <= SFID_PH_IGNORE;
            SFID_PH_OUT, SFID_PH_IGNORE: phase_r <= phase_r;
         endcase
      end
   end

   // Start of the output phase and the first byte to send
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         phase_d_r <= SFID_PH_CMD;
      else
         phase_d_r <= phase_r;
   end

   assign out_start = (phase_r == SFID_PH_OUT) && (phase_d_r != SFID_PH_OUT);

   // odd start address leads with device byte, except on the single-line read
   // only the low address byte counts
   always_comb
   begin
      start_idx = 8'h00;
      if (src_r == SFID_SRC_TABLE)
         start_idx = addr_r[7:0];
      else if (src_r == SFID_SRC_MFR_DEV && cmd_r != `SFID_OP_ID_SINGLE)
         start_idx = {7'h00, addr_r[0]};
   end

   // Response byte for the current index
   always_comb
   begin
      unique case (src_r)
         SFID_SRC_MFR_DEV: src_byte = idx_r[0] ? DEV_ID : MFR_ID;
         SFID_SRC_STD_ID:
            src_byte = (idx_r == 8'h00) ? MFR_ID :
                       (idx_r == 8'h01) ? MEM_TYPE : CAPACITY;
         SFID_SRC_UID: src_byte = UNIQUE_ID[{3'h7 - idx_r[2:0], 3'h0} +: 8];
         SFID_SRC_TABLE: src_byte = table_r[idx_r];
         SFID_SRC_STATUS: src_byte = status_byte;
         default: src_byte = 8'hff;
      endcase
   end

   // Generator fills the FIFO, stalled whenever it is full
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         prod_en_r <= 1'b0;
         idx_r <= 8'h00;
      end
      else if (pins_s2_r.cs_n)
         prod_en_r <= 1'b0;
      else if (out_start)
      begin
         prod_en_r <= 1'b1;
         idx_r <= start_idx;
      end
      else if (prod_en_r && fifo_ready)
      begin
         // alternation, the table wraps at 256
         if (src_r == SFID_SRC_STD_ID && idx_r == 8'h02)
            idx_r <= 8'h00;
         else
            idx_r <= idx_r + 8'h01;
      end
   end

   sfid_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .clr(pins_s2_r.cs_n),
      .in_valid(prod_en_r),
      .in_ready(fifo_ready),
      .in_data(src_byte),
      .out_valid(fifo_valid),
      .out_ready(pop),
      .out_data(fifo_data)
   );

   // A new byte is taken on the falling edge that starts it
   assign pop = sclk_fall && (phase_r == SFID_PH_OUT) && (out_left_r == 3'h0);
   // Status bypasses the FIFO so a polled busy flag is never stale
   assign cur_byte = (out_left_r != 3'h0) ? out_byte_r :
                     (src_r == SFID_SRC_STATUS) ? status_byte :
                     (fifo_valid ? fifo_data : 8'hff);

   // output shifter, MSB first on falling edges
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         spi_io_out <= 4'h0;
         spi_io_oe <= 4'h0;
         out_byte_r <= 8'h00;
         out_left_r <= 3'h0;
      end
      else if (pins_s2_r.cs_n)
      begin
         spi_io_oe <= 4'h0;
         out_left_r <= 3'h0;
      end
      else if (sclk_fall && phase_r == SFID_PH_OUT)
      begin
         unique case (out_lanes_r)
            SFID_LANE_1:
            begin
               spi_io_out <= {2'h0, cur_byte[7], 1'b0};
               spi_io_oe <= 4'h2;
               out_byte_r <= {cur_byte[6:0], 1'b0};
               out_left_r <= (out_left_r == 3'h0) ? 3'h7 : out_left_r - 3'h1;
            end
            SFID_LANE_2:
            begin
               spi_io_out <= {2'h0, cur_byte[7:6]};
               spi_io_oe <= 4'h3;
               out_byte_r <= {cur_byte[5:0], 2'h0};
               out_left_r <= (out_left_r == 3'h0) ? 3'h3 : out_left_r - 3'h1;
            end
            SFID_LANE_4:
            begin
               spi_io_out <= cur_byte[7:4];
               spi_io_oe <= 4'hf;
               out_byte_r <= {cur_byte[3:0], 4'h0};
               out_left_r <= (out_left_r == 3'h0) ? 3'h1 : out_left_r - 3'h1;
            end
         endcase
      end
   end

   // Frame ended exactly after the last instruction or address bit
   assign frame_end_hold = cs_rise && (phase_r == SFID_PH_HOLD);
   assign erase_sel = addr_r[15:12];

   assign erase_go = frame_end_hold && (cmd_r == `SFID_OP_SEC_ERASE) &&
                     write_latch_r && (addr_r[23:16] == 8'h00) &&
                     (addr_r[11:8] == 4'h0) && (erase_sel >= 4'h1) &&
                     (erase_sel <= 4'h3) &&
                     !otp_lock_bits_r[erase_sel[1:0] - 2'h1];
   assign erase_done = busy_r && (erase_cnt_r == 32'h0);

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         busy_r <= 1'b0;
         erase_cnt_r <= 32'h0;
         last_sel_r <= 2'h0;
         erase_total_r <= 8'h00;
      end
      else if (erase_go)
      begin
         busy_r <= 1'b1;
         erase_cnt_r <= 32'(ERASE_CYCLES - 1);
         last_sel_r <= erase_sel[1:0];
      end
      else if (erase_done)
      begin
         busy_r <= 1'b0;
         erase_total_r <= erase_total_r + 8'h01;
      end
      else if (busy_r)
         erase_cnt_r <= erase_cnt_r - 32'h1;
   end

   // Write latch; a set in the clearing cycle wins
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         write_latch_r <= 1'b0;
      else
      begin
         if (erase_done || (frame_end_hold && cmd_r == `SFID_OP_WRDI))
            write_latch_r <= 1'b0;
         if (frame_end_hold && cmd_r == `SFID_OP_WREN)
            write_latch_r <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         pd_r <= 1'b0;
      else if (frame_end_hold && cmd_r == `SFID_OP_PDOWN)
         pd_r <= 1'b1;
      else if (frame_end_hold && cmd_r == `SFID_OP_RELEASE)
         pd_r <= 1'b0;
   end

   // Status byte returned by the status read
   always_comb
   begin
      status_byte = 8'h00;
      status_byte[`SFID_SR_BUSY_BIT] = busy_r;
      status_byte[`SFID_SR_WL_BIT] = write_latch_r;
   end

   // lock bits only ever set; table loaded by software
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         otp_lock_bits_r <= 3'h0;
         tbl_idx_r <= 8'h00;
         for (int i = 0; i < 256; i++)
            table_r[i] <= `SFID_TABLE_RESET;
      end
      else if (reg_wr)
      begin
         if (reg_addr == `SFID_REG_LOCK)
            otp_lock_bits_r <= otp_lock_bits_r | reg_wdata[2:0];
         else if (reg_addr == `SFID_REG_TBL_IDX)
            tbl_idx_r <= reg_wdata[7:0];
         else if (reg_addr == `SFID_REG_TBL_DATA)
         begin
            table_r[tbl_idx_r] <= reg_wdata[7:0];
            tbl_idx_r <= tbl_idx_r + 8'h01;
         end
      end
   end

   // Read data stands only in the cycle after the read strobe
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         reg_rdata <= 32'h0;
      else if (!reg_rd)
         reg_rdata <= 32'h0;
      else
      begin
         reg_rdata <= 32'h0;
         unique case (reg_addr)
            `SFID_REG_STATUS:
            begin
               reg_rdata[`SFID_SR_BUSY_BIT] <= busy_r;
               reg_rdata[`SFID_SR_WL_BIT] <= write_latch_r;
               reg_rdata[`SFID_SR_PD_BIT] <= pd_r;
               reg_rdata[`SFID_SR_LOCK_LSB +: 3] <= otp_lock_bits_r;
            end
            `SFID_REG_LOCK: reg_rdata[2:0] <= otp_lock_bits_r;
            `SFID_REG_TBL_IDX: reg_rdata[7:0] <= tbl_idx_r;
            `SFID_REG_TBL_DATA: reg_rdata[7:0] <= table_r[tbl_idx_r];
            `SFID_REG_ERASE_INFO:
            begin
               reg_rdata[1:0] <= last_sel_r;
               reg_rdata[15:8] <= erase_total_r;
            end
            default: reg_rdata <= 32'h0;
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: pkg/sfid_consts.svh */
// Constants for the serial flash identity and security command block
`ifndef SFID_CONSTS_SVH
`define SFID_CONSTS_SVH

// Instruction codes
`define SFID_OP_ID_SINGLE 8'h90
`define SFID_OP_ID_DUAL 8'h92
`define SFID_OP_ID_QUAD 8'h94
`define SFID_OP_UID 8'h4b
`define SFID_OP_STD_ID 8'h9f
`define SFID_OP_TABLE 8'h5a
`define SFID_OP_SEC_ERASE 8'h44
`define SFID_OP_WREN 8'h06
`define SFID_OP_WRDI 8'h04
`define SFID_OP_RDSR 8'h05
`define SFID_OP_PDOWN 8'hb9
`define SFID_OP_RELEASE 8'hab

// Clock counts of each frame phase
`define SFID_CMD_CLKS 6'h08
`define SFID_ADDR_CLKS_1 6'h18
`define SFID_ADDR_CLKS_2 6'h0c
`define SFID_ADDR_CLKS_4 6'h06
`define SFID_MODE_CLKS 6'h04
`define SFID_QUAD_DUMMY_CLKS 6'h04
`define SFID_UID_DUMMY_CLKS 6'h20
`define SFID_TABLE_DUMMY_CLKS 6'h08

// Erase timing: time in microseconds and system clock rate in MHz
`define SFID_SEC_ERASE_TIME_US 100
`define SFID_CLK_MHZ 100

// Register offsets
`define SFID_REG_STATUS 8'h00
`define SFID_REG_LOCK 8'h04
`define SFID_REG_TBL_IDX 8'h08
`define SFID_REG_TBL_DATA 8'h0c
`define SFID_REG_ERASE_INFO 8'h10

// Status field positions, table reset value and FIFO depth
`define SFID_SR_BUSY_BIT 0
`define SFID_SR_WL_BIT 1
`define SFID_SR_PD_BIT 2
`define SFID_SR_LOCK_LSB 3
`define SFID_TABLE_RESET 8'hff
`define SFID_FIFO_DEPTH 32

`endif

/* File: pkg/sfid_pkg.sv */
// Types shared by the serial flash identity and security command block
`default_nettype none
package sfid_pkg;

   // Phase of the current select-low frame
   typedef enum logic [2:0] {
      SFID_PH_CMD,
      SFID_PH_ADDR,
      SFID_PH_MODE,
      SFID_PH_DUMMY,
      SFID_PH_OUT,
      SFID_PH_HOLD,
      SFID_PH_IGNORE
   } sfid_phase_t;

   // Source of the bytes shifted out
   typedef enum logic [2:0] {
      SFID_SRC_MFR_DEV,
      SFID_SRC_STD_ID,
      SFID_SRC_UID,
      SFID_SRC_TABLE,
      SFID_SRC_STATUS
   } sfid_src_t;

   // Number of data lines in use
   typedef enum logic [1:0] {
      SFID_LANE_1,
      SFID_LANE_2,
      SFID_LANE_4
   } sfid_lanes_t;

   // Link pins as sampled
   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic [3:0] io;
   } sfid_pins_t;

endpackage
`default_nettype wire

/* File: design/sfid_fifo.sv */
// Byte FIFO between the response generator and the output shifter
`default_nettype none
`timescale 1ns/1ps
module sfid_fifo
   import sfid_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
)
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic clr,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic push;
   logic pop;

   // Honest full and empty flags
   assign in_ready = (count_r != (AW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem_r[rd_ptr_r];

   // Storage, written at the write pointer
   always_ff @(posedge clk_sys)
   begin
      if (push)
         mem_r[wr_ptr_r] <= in_data;
   end

   // Pointers and fill count; clear empties the FIFO
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end
      else if (clr)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         if (pop)
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         if (push && !pop)
            count_r <= count_r + 1'b1;
         else if (pop && !push)
            count_r <= count_r - 1'b1;
      end
   end
endmodule
`default_nettype wire

/* File: bench/sfid_host.sv */
// Host link master model: select, clock and data lines
`default_nettype none
`timescale 1ns/1ps
module sfid_host
(
   input wire logic clk_sys,
   output logic spi_cs_n,
   output logic spi_sclk,
   output logic [3:0] spi_io_in,
   input wire logic [3:0] spi_io_out,
   input wire logic [3:0] spi_io_oe
);
   logic [3:0] hv;
   logic [63:0] q;
   logic act;
   // Line level: device where enabled, else the host value
   assign spi_io_in = (spi_io_oe & spi_io_out) | (~spi_io_oe & hv);
   initial
   begin
      spi_cs_n = 1'b1;
      spi_sclk = 1'b0;
      hv = 4'h0;
      act = 1'b0;
   end
   // Remembers any drive seen in a frame
   always @(posedge clk_sys)
      if (|spi_io_oe)
         act <= 1'b1;
   // groups MSB first; released lines toggle
   task sh(input logic [63:0] d, input int n, input int w, input bit rd);
      logic [3:0] m;
      m = (w == 1) ? 4'h1 : (w == 2) ? 4'h3 : 4'hf;
      q = 64'h0;
      for (int k = n - 1; k >= 0; k--)
      begin
         hv <= rd ? ~hv : (~hv & ~m) | (4'(d >> (k * w)) & m);
         repeat (4) @(posedge clk_sys);
         spi_sclk <= 1'b1;
         repeat (4) @(posedge clk_sys);
         q = (q << w) | ((w == 1) ? 64'(spi_io_in[1]) : 64'(spi_io_in & m));
         spi_sclk <= 1'b0;
      end
   endtask
   // whole frame, select raised right after last clock
   task rx(input logic [7:0] op, input logic [63:0] d, input int n,
      input int w, input int no, input int wo);
      @(posedge clk_sys);
      spi_cs_n <= 1'b0;
      act = 1'b0;
      sh(64'(op), 8, 1, 1'b0);
      sh(d, n, w, 1'b0);
      sh(64'h0, no, wo, 1'b1);
      @(posedge clk_sys);
      spi_cs_n <= 1'b1;
      repeat (8) @(posedge clk_sys);
   endtask
endmodule
`default_nettype wire

/* File: bench/sfid_chk.sv */
// Port checker for the identity and erase command block
`default_nettype none
`timescale 1ns/1ps
module sfid_chk
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic spi_cs_n,
   input wire logic [3:0] spi_io_oe,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   logic st_rd_r;
   logic pd_seen_r;
   // Power-down flag as last shown by a status read
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         st_rd_r <= 1'b0;
         pd_seen_r <= 1'b0;
      end
      else
      begin
         st_rd_r <= reg_rd && reg_addr == 8'h00;
         if (st_rd_r)
            pd_seen_r <= reg_rdata[2];
      end
   end
   // Lock write followed by a status read
   sequence s_lock;
      reg_wr && reg_addr == 8'h04 ##2 reg_rd && reg_addr == 8'h00;
   endsequence
   a_oe_lanes: assert property (spi_io_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
      else $error("bad lane enable");
   a_oe_idle: assert property (spi_cs_n [*6] |-> spi_io_oe == 4'h0)
      else $error("drive with select high");
   a_oe_early: assert property ($fell(spi_cs_n) |-> (spi_io_oe == 4'h0) [*8])
      else $error("drive too early");
   a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data without read");
   a_rd_unmap: assert property (reg_rd && reg_addr == 8'h20 |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   a_stat_high: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata[31:6] == 26'h0)
      else $error("status high bits set");
   a_lock_shown: assert property (s_lock |=> (reg_rdata[5:3] & $past(reg_wdata[2:0], 3)) == $past(reg_wdata[2:0], 3))
      else $error("lock bit not kept");
   a_pd_quiet: assert property (pd_seen_r |-> spi_io_oe == 4'h0)
      else $error("drive in power down");
endmodule
bind sfid_top sfid_chk u_chk (.clk_sys, .resetn, .spi_cs_n, .spi_io_oe,
   .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench for identity reads and security erase
`default_nettype none
`timescale 1ns/1ps
module tb;
   localparam logic [7:0] M = 8'h5c;
   localparam logic [7:0] D = 8'h16;
   localparam logic [15:0] TC = 16'h6017;
   localparam logic [63:0] U = 64'h0123_4567_89ab_cdef;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic spi_cs_n, spi_sclk;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [3:0] spi_io_in, spi_io_out, spi_io_oe;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] reg_rdata, s;
   int err_total = 0;
   int compares = 0;
   // Clock and instances
   always #5 clk_sys = ~clk_sys;
   sfid_top #(.MFR_ID(M), .DEV_ID(D), .MEM_TYPE(TC[15:8]), .CAPACITY(TC[7:0]),
      .UNIQUE_ID(U), .ERASE_CYCLES(400)) u_sfid_top (
      .clk_sys, .resetn, .spi_cs_n, .spi_sclk, .spi_io_in, .spi_io_out,
      .spi_io_oe, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
   sfid_host u_sfid_host (.clk_sys, .spi_cs_n, .spi_sclk, .spi_io_in,
      .spi_io_out, .spi_io_oe);
   task summarize;
      if (err_total == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task cmp(input logic [63:0] g, input logic [63:0] e);
      compares++;
      if (g !== e)
      begin
         err_total++;
         $display("BAD %0t %h %h", $time, g, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 s = reg_rdata;
   endtask
   // Identity reads on one, two and four lines
   task t_ids;
      u_sfid_host.rx(8'h9f, 0, 0, 1, 24, 1);
      cmp(u_sfid_host.q, {M, TC});
      u_sfid_host.rx(8'h90, 0, 24, 1, 16, 1);
      cmp(u_sfid_host.q, {M, D});
      u_sfid_host.rx(8'h92, 64'h1f0, 16, 2, 12, 2);
      cmp(u_sfid_host.q, {D, M, D});
      u_sfid_host.rx(8'h94, 0, 10, 4, 4, 4);
      cmp(u_sfid_host.q, {M, D});
      u_sfid_host.rx(8'h4b, 0, 32, 1, 64, 1);
      cmp(u_sfid_host.q, U);
   endtask
   // Parameter table read across the index wrap
   task t_table;
      wr(8'h08, 32'hff);
      wr(8'h0c, 32'ha5);
      wr(8'h0c, 32'h3c);
      u_sfid_host.rx(8'h5a, 64'hff00, 32, 1, 16, 1);
      cmp(u_sfid_host.q, 64'ha53c);
   endtask
   // Erase gating, busy time, latch clear and locks
   task t_erase;
      u_sfid_host.rx(8'h44, 64'h1000, 24, 1, 0, 1);
      rd(8'h00);
      cmp(s[1:0], 2'h0);
      u_sfid_host.rx(8'h06, 0, 0, 1, 0, 1);
      u_sfid_host.rx(8'h44, 64'h1000, 24, 1, 0, 1);
      rd(8'h00);
      cmp(s[1:0], 2'h3);
      u_sfid_host.rx(8'h05, 0, 0, 1, 8, 1);
      cmp(u_sfid_host.q[1:0], 2'h3);
      for (int i = 0; i < 500 && s[0] !== 1'b0; i++)
         rd(8'h00);
      if (s[0] !== 1'b0)
      begin
         err_total++;
         summarize;
      end
      cmp(s[1:0], 2'h0);
      rd(8'h10);
      cmp(s[1:0], 2'h1);
      wr(8'h04, 32'h2);
      rd(8'h00);
      u_sfid_host.rx(8'h06, 0, 0, 1, 0, 1);
      u_sfid_host.rx(8'h44, 64'h2000, 24, 1, 0, 1);
      rd(8'h00);
      cmp(s[1:0], 2'h2);
      u_sfid_host.rx(8'h44, 64'h1100, 24, 1, 0, 1);
      rd(8'h00);
      cmp(s[1:0], 2'h2);
      u_sfid_host.rx(8'h44, 64'h6000, 25, 1, 0, 1);
      rd(8'h00);
      cmp(s[1:0], 2'h2);
      rd(8'h20);
      cmp(s, 32'h0);
   endtask
   // Power down silences reads until release
   task t_pdown;
      u_sfid_host.rx(8'hb9, 0, 0, 1, 0, 1);
      rd(8'h00);
      cmp(s[2], 1'b1);
      u_sfid_host.rx(8'h9f, 0, 0, 1, 8, 1);
      cmp(u_sfid_host.act, 1'b0);
      u_sfid_host.rx(8'hab, 0, 0, 1, 0, 1);
      rd(8'h00);
      cmp(s[2], 1'b0);
      u_sfid_host.rx(8'h9f, 0, 0, 1, 8, 1);
      cmp(u_sfid_host.q, M);
   endtask
   // Reset, then the scenarios in turn
   initial
   begin
      repeat (3) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      t_ids;
      t_table;
      t_erase;
      t_pdown;
      summarize;
   end
endmodule
`default_nettype wire
